//--- logic/smctr_map_mem.sv
// Request-to-module mapping memory with registered read data
`timescale 1ns/1ps
module smctr_map_mem (
  input  wire logic                           clk,
  input  wire logic                           we,
  input  wire logic [smctr_pkg::REQ_W-1:0]    waddr,
  input  wire logic [smctr_pkg::REQ_W-1:0]    wdata,
  input  wire logic [smctr_pkg::REQ_W-1:0]    raddr,
  output logic      [smctr_pkg::REQ_W-1:0]    rdata
);

  logic [smctr_pkg::REQ_W-1:0] mem [smctr_pkg::NUM_REQ];

  // Write port
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end

endmodule : smctr_map_mem

//--- logic/smctr_pkg.sv
// Package: constants and carriers for the socket manager command and request registers
package smctr_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int unsigned NUM_REQ   = 16;                  // Requests allocated to this manager
  localparam int unsigned REQ_W     = $clog2(NUM_REQ);     // Request field and map entry width
  localparam int unsigned DATA_W    = 32;

  // ------------------------------------------------------------------
  // Register selection (bank in upper address bits, row in lower)
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned BANK_LSB  = 10;
  localparam logic [1:0]  BANK_CTRL = 2'h0;                // Bank 0: status/command, request word
  localparam logic [1:0]  BANK_MAP  = 2'h1;                // Bank 1: request map rows
  localparam logic [9:0]  SEL_STATUS = 10'h000;            // Status read / command write
  localparam logic [9:0]  SEL_SWREQ  = 10'h001;            // Software request word

  // ------------------------------------------------------------------
  // Command word fields
  // ------------------------------------------------------------------
  localparam int unsigned UARG_MSB  = 31;
  localparam int unsigned UARG_LSB  = 16;
  localparam int unsigned MARG_MSB  = 15;
  localparam int unsigned MARG_LSB  = 8;
  localparam int unsigned CODE_MSB  = 7;
  localparam int unsigned CODE_LSB  = 0;
  localparam logic [7:0]  CMD_SHUTDOWN   = 8'h00;
  localparam logic [7:0]  CMD_RESTART_NS = 8'h01;
  localparam logic [7:0]  CMD_RESTART_ST = 8'h02;
  localparam logic [7:0]  CMD_PROCEED    = 8'h03;
  localparam logic [7:0]  CMD_USER       = 8'h04;

  // ------------------------------------------------------------------
  // Status and request word fields
  // ------------------------------------------------------------------
  localparam int unsigned STAT_SHUT_BIT = 7;
  localparam int unsigned PEND_BIT      = 31;
  localparam logic        SHUT_RESET    = 1'b1;            // Manager starts shut down

  typedef enum logic [2:0] {
    SMCTR_NONE, SMCTR_SHUTDOWN, SMCTR_RESTART_NS, SMCTR_RESTART_ST, SMCTR_PROCEED, SMCTR_USER
  } smctr_cmd_e;

  // Decoded command carrier
  typedef struct packed {
    logic        valid;
    smctr_cmd_e  cmd;
    logic [15:0] upper_argument;
    logic [7:0]  middle_argument;
  } smctr_cmd_s;

  // Register port request carrier
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } smctr_req_s;

endpackage : smctr_pkg

//--- logic/smctr_regs.sv
// Command word, software request word and request map bank of one socket manager
`timescale 1ns/1ps
// Behaviour
// - Command word is write-only, shares address with status; reads there return status.
// - Command word splits into upper 31:16, middle 15:8, code 7:0.
// - Codes 0..4: shutdown, restart plain, restart with status, proceed, user.
// - Request word bit 31 reads pending flag; writes to bit 31 ignored.
// - Request field is W bits; bits 30 to W ignore writes, read zero.
// - Written request selects map row; new write replaces pending request.
// - Map entry per request index holds module identifier to load.
// - Several request indices may map to one module.
// - Map entry stores low X bits; higher bits ignore writes, read zero.
// - Map bank accessible only when shut down; else reads zero, writes dropped.
// - Status bit 7 reports shutdown, same condition gating map access.
module smctr_regs (
  input  wire logic                              clk,
  input  wire logic                              nrst,
  input  wire smctr_pkg::smctr_req_s             reg_req,
  output logic      [smctr_pkg::DATA_W-1:0]      reg_rdata,
  output logic                                   reg_rvalid,
  input  wire logic                              req_taken,
  output smctr_pkg::smctr_cmd_s                  cmd_out,
  output logic                                   shutdown,
  output logic                                   req_pending,
  output logic      [smctr_pkg::REQ_W-1:0]       req_index,
  output logic      [smctr_pkg::REQ_W-1:0]       module_identifier
);

  localparam int unsigned W = smctr_pkg::REQ_W;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  function automatic logic sel_is(input logic [smctr_pkg::ADDR_W-1:0] a, input logic [1:0] bank,
                                  input logic [9:0] row);
    sel_is = (a[smctr_pkg::ADDR_W-1:smctr_pkg::BANK_LSB] == bank) && (a[9:0] == row);
  endfunction : sel_is

  logic                          is_map;
  logic                          wr_cmd;
  logic                          wr_swreq;
  logic                          wr_map;
  logic [7:0]                    code;
  smctr_pkg::smctr_cmd_e         dec_cmd;
  logic                          shut_r;
  logic                          pend_r;
  logic [W-1:0]                  req_r;
  logic [W-1:0]                  map_rdata;
  logic                          rd_d_r;
  logic [1:0]                    rd_kind_r;
  logic                          rd_shut_r;
  logic [W-1:0]                  mod_r;
  logic                          lookup_r;

  assign is_map = (reg_req.addr[smctr_pkg::ADDR_W-1:smctr_pkg::BANK_LSB] == smctr_pkg::BANK_MAP)
                  && (reg_req.addr[9:W] == '0);
  assign wr_cmd   = reg_req.wr && sel_is(reg_req.addr, smctr_pkg::BANK_CTRL, smctr_pkg::SEL_STATUS);
  assign wr_swreq = reg_req.wr && sel_is(reg_req.addr, smctr_pkg::BANK_CTRL, smctr_pkg::SEL_SWREQ);
  assign wr_map   = reg_req.wr && is_map && shut_r;

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------
  // code field
  assign code = reg_req.wdata[smctr_pkg::CODE_MSB:smctr_pkg::CODE_LSB];

  always_comb
  begin
    unique case (code)
      smctr_pkg::CMD_SHUTDOWN:   dec_cmd = smctr_pkg::SMCTR_SHUTDOWN;
      smctr_pkg::CMD_RESTART_NS: dec_cmd = smctr_pkg::SMCTR_RESTART_NS;
      smctr_pkg::CMD_RESTART_ST: dec_cmd = smctr_pkg::SMCTR_RESTART_ST;
      smctr_pkg::CMD_PROCEED:    dec_cmd = smctr_pkg::SMCTR_PROCEED;
      smctr_pkg::CMD_USER:       dec_cmd = smctr_pkg::SMCTR_USER;
      default:                   dec_cmd = smctr_pkg::SMCTR_NONE;
    endcase
  end

  // reserved codes give no command pulse
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cmd_out <= '0;
    end
    else
    begin
      cmd_out.valid           <= wr_cmd && (dec_cmd != smctr_pkg::SMCTR_NONE);
      cmd_out.cmd             <= wr_cmd ? dec_cmd : smctr_pkg::SMCTR_NONE;
      cmd_out.upper_argument  <= reg_req.wdata[smctr_pkg::UARG_MSB:smctr_pkg::UARG_LSB];
      cmd_out.middle_argument <= reg_req.wdata[smctr_pkg::MARG_MSB:smctr_pkg::MARG_LSB];
    end
  end

  // ------------------------------------------------------------------
  // Manager shutdown state
  // ------------------------------------------------------------------
  // shutdown flag from commands
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      shut_r <= smctr_pkg::SHUT_RESET;
    end
    else if (wr_cmd && dec_cmd == smctr_pkg::SMCTR_SHUTDOWN)
    begin
      shut_r <= 1'b1;
    end
    else if (wr_cmd && (dec_cmd == smctr_pkg::SMCTR_RESTART_NS || dec_cmd == smctr_pkg::SMCTR_RESTART_ST))
    begin
      shut_r <= 1'b0;
    end
  end

  assign shutdown = shut_r;

  // ------------------------------------------------------------------
  // Software request
  // ------------------------------------------------------------------
  // write replaces pending request; set wins over taken
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pend_r <= 1'b0;
      req_r  <= '0;
    end
    else if (wr_swreq)
    begin
      req_r  <= reg_req.wdata[W-1:0];
      pend_r <= 1'b1;
    end
    else if (req_taken)
    begin
      pend_r <= 1'b0;
    end
  end

  assign req_pending = pend_r;
  assign req_index   = req_r;

  // ------------------------------------------------------------------
  // Mapping bank
  // ------------------------------------------------------------------
  // one X-bit identifier per request row
  smctr_map_mem u_map (
    .clk   (clk),
    .we    (wr_map),
    .waddr (reg_req.addr[W-1:0]),
    .wdata (reg_req.wdata[W-1:0]),
    .raddr (reg_req.rd ? reg_req.addr[W-1:0] : req_r),
    .rdata (map_rdata)
  );

  // Lookup of the pending request's module, on idle read port cycles
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      lookup_r <= 1'b0;
      mod_r    <= '0;
    end
    else
    begin
      lookup_r <= !reg_req.rd;
      if (lookup_r)
      begin
        mod_r <= map_rdata;
      end
    end
  end

  assign module_identifier = mod_r;

  // ------------------------------------------------------------------
  // Read path, one cycle latency
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rd_d_r    <= 1'b0;
      rd_kind_r <= 2'h0;
      rd_shut_r <= 1'b0;
    end
    else
    begin
      rd_d_r    <= reg_req.rd;
      rd_shut_r <= shut_r;
      if (sel_is(reg_req.addr, smctr_pkg::BANK_CTRL, smctr_pkg::SEL_STATUS))
        rd_kind_r <= 2'h1;
      else if (sel_is(reg_req.addr, smctr_pkg::BANK_CTRL, smctr_pkg::SEL_SWREQ))
        rd_kind_r <= 2'h2;
      else if (is_map)
        rd_kind_r <= 2'h3;
      else
        rd_kind_r <= 2'h0;
    end
  end

  // Read data mux
  always_comb
  begin
    reg_rdata  = '0;
    reg_rvalid = rd_d_r;
    if (rd_d_r)
    begin
      unique case (rd_kind_r)
        2'h1: reg_rdata[smctr_pkg::STAT_SHUT_BIT] = shut_r;
        2'h2:
        begin
          reg_rdata[smctr_pkg::PEND_BIT] = pend_r;
          reg_rdata[W-1:0]               = req_r;
        end
        // map read zero unless shut down
        2'h3: reg_rdata[W-1:0] = rd_shut_r ? map_rdata : '0;
        default: reg_rdata = '0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_map_wr_gate: assert property (@(posedge clk) disable iff (!nrst)
    (reg_req.wr && is_map && !shut_r) |-> !wr_map) else $error("map write while running");
  a_map_rd_zero: assert property (@(posedge clk) disable iff (!nrst)
    (reg_req.rd && is_map && !shut_r) |=> (reg_rdata == '0)) else $error("map read not zero");
  a_req_replace: assert property (@(posedge clk) disable iff (!nrst)
    wr_swreq |=> (pend_r && req_r == $past(reg_req.wdata[W-1:0]))) else $error("request not stored");
  a_pend_read: assert property (@(posedge clk) disable iff (!nrst)
    (reg_req.rd && sel_is(reg_req.addr, smctr_pkg::BANK_CTRL, smctr_pkg::SEL_SWREQ) && !wr_swreq)
    |=> (reg_rdata[smctr_pkg::PEND_BIT] == $past(pend_r) || $past(req_taken))) else $error("pending bit wrong");
  a_swreq_zero: assert property (@(posedge clk) disable iff (!nrst)
    (rd_d_r && rd_kind_r != 2'h1) |-> (reg_rdata[smctr_pkg::PEND_BIT-1:W] == '0)) else $error("reserved bits nonzero");
  a_shut_cmd: assert property (@(posedge clk) disable iff (!nrst)
    (wr_cmd && code == smctr_pkg::CMD_SHUTDOWN) |=> shut_r) else $error("shutdown not entered");
  a_rsvd_cmd: assert property (@(posedge clk) disable iff (!nrst)
    (wr_cmd && code > smctr_pkg::CMD_USER) |=> (!cmd_out.valid && $stable(shut_r))) else $error("reserved cmd acted");
  a_cmd_args: assert property (@(posedge clk) disable iff (!nrst)
    wr_cmd |=> (cmd_out.upper_argument == $past(reg_req.wdata[smctr_pkg::UARG_MSB:smctr_pkg::UARG_LSB])))
    else $error("argument split wrong");
  a_status_rd: assert property (@(posedge clk) disable iff (!nrst)
    (reg_req.rd && sel_is(reg_req.addr, smctr_pkg::BANK_CTRL, smctr_pkg::SEL_STATUS) && !wr_cmd)
    |=> (reg_rdata[smctr_pkg::STAT_SHUT_BIT] == shut_r)) else $error("status read wrong");

endmodule : smctr_regs

//--- verification/test_smctr_regs.sv
// Testbench: register-level checks of the socket manager command and request registers
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module test_smctr_regs;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic                                 clk = 1'b0;
  logic                                 nrst;
  smctr_pkg::smctr_req_s                reg_req;
  logic      [smctr_pkg::DATA_W-1:0]    reg_rdata;
  logic                                 reg_rvalid;
  logic                                 req_taken;
  smctr_pkg::smctr_cmd_s                cmd_out;
  logic                                 shutdown;
  logic                                 req_pending;
  logic      [smctr_pkg::REQ_W-1:0]     req_index;
  logic      [smctr_pkg::REQ_W-1:0]     module_identifier;
  int                                   mismatches = 0;
  int                                   cmp_count = 0;
  int                                   i;
  logic                                 shut_exp;
  logic      [7:0]                      codes [5] = '{8'h01, 8'h03, 8'h04, 8'h00, 8'h02};
  logic      [7:0]                      rsv [3] = '{8'h05, 8'h08, 8'hFF};

  // ------------------------------------------------------------------
  // Design under test
  // ------------------------------------------------------------------
  smctr_regs smctr_regs_inst (
    .clk               (clk),
    .nrst              (nrst),
    .reg_req           (reg_req),
    .reg_rdata         (reg_rdata),
    .reg_rvalid        (reg_rvalid),
    .req_taken         (req_taken),
    .cmd_out           (cmd_out),
    .shutdown          (shutdown),
    .req_pending       (req_pending),
    .req_index         (req_index),
    .module_identifier (module_identifier)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // ------------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------------
  // One write strobe, effect settled on return
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    reg_req <= '0;
    #1;
  endtask : wr

  // One read strobe, answer checked in its valid cycle
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_req <= {1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk);
    reg_req <= '0;
    #1;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask : rd

  // Verdict and end of run
  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog against a hung run
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    reg_req = '0;
    req_taken = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    `CHK(shutdown, 1'b1)
    `CHK(req_pending, 1'b0)
    rd(12'h000, 32'h0000_0080);
    // Fill map with junk upper bits, pairs of rows sharing a module
    for (i = 0; i < 16; i++)
      wr(12'(12'h400 + i), 32'hABCD_EF00 | 32'(i >> 1));
    for (i = 0; i < 16; i++)
      rd(12'(12'h400 + i), 32'(i >> 1));
    rd(12'h410, 32'h0000_0000);
    rd(12'h002, 32'h0000_0000);
    // Request word: reserved bits and pending flag
    wr(12'h001, 32'hFFFF_FFF5);
    `CHK(req_pending, 1'b1)
    `CHK(req_index, 4'h5)
    rd(12'h001, 32'h8000_0005);
    repeat (3) @(posedge clk);
    #1;
    `CHK(module_identifier, 4'h2)
    wr(12'h001, 32'h0000_0009);
    `CHK(req_index, 4'h9)
    `CHK(req_pending, 1'b1)
    @(posedge clk);
    req_taken <= 1'b1;
    @(posedge clk);
    req_taken <= 1'b0;
    #1;
    `CHK(req_pending, 1'b0)
    rd(12'h001, 32'h0000_0009);
    `CHK(module_identifier, 4'h4)
    // Every defined command, status read back at the shared address
    shut_exp = 1'b1;
    foreach (codes[k])
    begin
      wr(12'h000, {16'hBEEF, 8'h12, codes[k]});
      if (codes[k] == 8'h00)
        shut_exp = 1'b1;
      else if (codes[k] == 8'h01 || codes[k] == 8'h02)
        shut_exp = 1'b0;
      `CHK(cmd_out.valid, 1'b1)
      `CHK(cmd_out.cmd, smctr_pkg::smctr_cmd_e'(codes[k][2:0] + 3'h1))
      `CHK(cmd_out.upper_argument, 16'hBEEF)
      `CHK(cmd_out.middle_argument, 8'h12)
      `CHK(shutdown, shut_exp)
      rd(12'h000, {24'h0, shut_exp, 7'h0});
      `CHK(cmd_out.valid, 1'b0)
    end
    // Map gated while running
    rd(12'h403, 32'h0000_0000);
    wr(12'h403, 32'h0000_000F);
    // Reserved codes leave state and pending request alone
    wr(12'h001, 32'h0000_0007);
    foreach (rsv[k])
    begin
      wr(12'h000, {24'h0, rsv[k]});
      `CHK(cmd_out.valid, 1'b0)
      `CHK(shutdown, 1'b0)
      `CHK(req_pending, 1'b1)
      `CHK(req_index, 4'h7)
    end
    wr(12'h000, 32'h0000_0000);
    `CHK(shutdown, 1'b1)
    rd(12'h403, 32'h0000_0001);
    end_sim();
  end

endmodule : test_smctr_regs
